// ### logic/vfbsr_pkg.sv
package vfbsr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_FIRST = 6'h0E;
    localparam logic [5:0] IDX_PIN_INPUT_CONTROL = 6'h0E;
    localparam logic [5:0] IDX_RESERVED_0F = 6'h0F;
    localparam logic [5:0] IDX_VIDEO_PORT_CONFIG = 6'h10;
    localparam logic [5:0] IDX_VIDEO_TYPE_MATCH_VALUE = 6'h11;
    localparam logic [5:0] IDX_RESERVED_12 = 6'h12;
    localparam logic [5:0] IDX_FORCED_TEST_ERROR = 6'h13;
    localparam logic [5:0] IDX_TEST_MODE_CONTROL = 6'h14;
    localparam logic [5:0] IDX_SENSOR_VOLTAGE_GAIN = 6'h15;
    localparam logic [5:0] IDX_RESERVED_16 = 6'h16;
    localparam logic [5:0] IDX_SENSOR_CONTROL_ZERO = 6'h17;
    localparam logic [5:0] IDX_SENSOR_CONTROL_ONE = 6'h18;
    localparam logic [5:0] IDX_VOLTAGE0_THRESHOLDS = 6'h19;
    localparam logic [5:0] IDX_LAST = 6'h19;

    // Reset values
    localparam logic [7:0] RST_PIN_INPUT_CONTROL = 8'h0F;
    localparam logic [7:0] RST_RESERVED_0F = 8'h00;
    localparam logic [7:0] RST_VIDEO_PORT_CONFIG = 8'h00;
    localparam logic [7:0] RST_VIDEO_TYPE_MATCH_VALUE = 8'h00;
    localparam logic [7:0] RST_RESERVED_12 = 8'h00;
    localparam logic [7:0] RST_FORCED_TEST_ERROR = 8'h00;
    localparam logic [7:0] RST_TEST_MODE_CONTROL = 8'h00;
    localparam logic [7:0] RST_SENSOR_VOLTAGE_GAIN = 8'h20;
    localparam logic [7:0] RST_RESERVED_16 = 8'h18;
    localparam logic [7:0] RST_SENSOR_CONTROL_ZERO = 8'h0C;
    localparam logic [7:0] RST_SENSOR_CONTROL_ONE = 8'h80;
    localparam logic [7:0] RST_VOLTAGE0_THRESHOLDS = 8'h62;

    // Writable bit masks where some bits are read-only
    localparam logic [7:0] MASK_RESERVED_0F = 8'h0F;

    // Field positions
    localparam int BIT_PIN0_OUTPUT_ENABLE = 4;
    localparam int BIT_ANY_LONG_TYPE_PASS = 4;
    localparam int BIT_TYPE_MATCH_ENABLE = 3;
    localparam int BIT_YUV10_TYPE_PASS = 2;
    localparam int BIT_FRAME_VALID_INVERT = 1;
    localparam int BIT_LINE_VALID_INVERT = 0;
    localparam int BIT_FORCE_GO = 7;
    localparam int BIT_LOCAL_TEST_MODE = 3;
    localparam int BIT_REMOTE_TEST_ENABLE = 0;
    localparam int BIT_GAIN_ENABLE = 7;

    // Packet type codes
    localparam logic [5:0] YUV10_CODE_A = 6'h19;
    localparam logic [5:0] YUV10_CODE_B = 6'h1D;
    localparam logic [5:0] YUV10_CODE_C = 6'h1F;

    // Test clock source encodings on the output port
    localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h0;
    localparam logic [1:0] CLK_SRC_INT_50 = 2'h1;
    localparam logic [1:0] CLK_SRC_INT_25 = 2'h2;

    // Sensor enable field value that turns the sensors on
    localparam logic [1:0] SENSORS_ON = 2'h3;

    // Error injector states
    typedef enum logic {INJ_IDLE, INJ_RUN} vfbsr_inj_state_t;

endpackage

// ### logic/vfbsr_sync.sv
`timescale 1ns/1ps
module vfbsr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [WIDTH-1:0] ASYNC_IN,
    output logic [WIDTH-1:0] SYNC_OUT
);

    logic [WIDTH-1:0] stage1_reg;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("vfbsr_sync needs WIDTH of at least one");
        end
    endgenerate

    // Two flip-flop chain; first stage feeds only the second
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            stage1_reg <= '0;
            SYNC_OUT <= '0;
        end else if (CLK_EN) begin
            stage1_reg <= ASYNC_IN;
            SYNC_OUT <= stage1_reg;
        end
    end

endmodule

// ### logic/vfbsr_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Four pin input enables, reset enabled
// - Pin 0 output enable bit, reset off
// - Any-long enable passes every long type
// - Match enable passes the stored type
// - Match value writes ignored while matching
// - YUV enable passes 10-bit YUV at 100MHz
// - Invert frame and line valid on request
// - Match uses bits 5:0, any mode
// - Match only for long stored values
// - Seven-bit count of errors to inject
// - Test mode entry injects errors automatically
// - Writing go bit injects in normal mode
// - Two-bit test clock source select
// - Remote test enable bit, reset zero
// - Nonzero four-bit field requests forced errors
// - Gain equals 128 over divisor, reset 0x20
// - Sensor enable field, reset both enabled
// - Pin sense select for voltage measurement
// - Gain applies only with gain enable
// - Voltage 0 above upper limit raises alarm
// - Voltage 0 below lower limit raises alarm
module vfbsr_top
    import vfbsr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [3:0] PIN_INPUT_ENABLE,
    output logic PIN0_OUTPUT_ENABLE,
    input wire logic FRAME_VALID_PIN,
    input wire logic LINE_VALID_PIN,
    output logic FRAME_VALID_OUT,
    output logic LINE_VALID_OUT,
    input wire logic VIDEO_100MHZ_MODE,
    input wire logic PKT_TYPE_STROBE,
    input wire logic [5:0] PKT_TYPE_CODE,
    output logic PKT_PASS_STROBE,
    output logic PKT_PASS,
    output logic LOCAL_TEST_MODE,
    output logic REMOTE_TEST_ENABLE,
    output logic [1:0] TEST_CLOCK_SOURCE,
    output logic FORWARD_ERROR_FORCE,
    output logic PARITY_ERROR_INJECT,
    output logic SENSORS_ENABLE,
    output logic VOLTAGE_SENSE_PIN0,
    output logic VOLTAGE_SENSE_PIN1,
    output logic [6:0] GAIN_DIVISOR,
    output logic GAIN_APPLY,
    input wire logic [2:0] VOLTAGE0_LEVEL,
    output logic VOLTAGE0_HIGH_ALARM,
    output logic VOLTAGE0_LOW_ALARM
);

    generate
        if (ADDR_W < 7) begin : g_chk
            $error("vfbsr_top needs ADDR_W of at least seven");
        end
    endgenerate

    logic [7:0] pin_input_control_reg;
    logic [7:0] reserved_0f_reg;
    logic [7:0] video_port_config_reg;
    logic [7:0] video_type_match_value_reg;
    logic [7:0] reserved_12_reg;
    logic [6:0] forced_parity_error_count_reg;
    logic force_parity_error_go_reg;
    logic [7:0] test_mode_control_reg;
    logic [7:0] sensor_voltage_gain_reg;
    logic [7:0] reserved_16_reg;
    logic [7:0] sensor_control_zero_reg;
    logic [7:0] sensor_control_one_reg;
    logic [7:0] voltage0_thresholds_reg;
    logic wait_reg;
    logic [6:0] wr_dec;
    logic [6:0] rd_dec;
    logic wr_take;
    logic [7:0] wdata;
    logic [7:0] read_value;
    logic [4:0] sync_in;
    logic [4:0] sync_out;
    logic local_prev_reg;
    logic entry_req_reg;
    logic start_req;
    vfbsr_inj_state_t inj_state_reg;
    logic [6:0] inj_cnt_reg;
    logic sense_pin0;

    // Word index and hit flag for a byte address
    function automatic logic [6:0] reg_decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = addr >> 2;
        reg_decode = {(addr[1:0] == 2'h0) && (word >= ADDR_W'(IDX_FIRST))
                      && (word <= ADDR_W'(IDX_LAST)), word[5:0]};
    endfunction

    // Packet type filter decision
    function automatic logic pass_decide(input logic [5:0] code, input logic [7:0] cfg,
                                         input logic [5:0] match, input logic mode100);
        logic long_code;
        logic match_long;
        logic yuv_code;
        long_code = code[5] | code[4];
        match_long = match[5] | match[4];
        yuv_code = (code == YUV10_CODE_A) || (code == YUV10_CODE_B) || (code == YUV10_CODE_C);
        pass_decide = (cfg[BIT_ANY_LONG_TYPE_PASS] && long_code)
            || (cfg[BIT_TYPE_MATCH_ENABLE] && match_long && code == match)
            || (cfg[BIT_YUV10_TYPE_PASS] && mode100 && yuv_code);
    endfunction

    assign wr_dec = reg_decode(AVS_ADDRESS);
    assign rd_dec = wr_dec;
    assign wdata = AVS_WRITEDATA[7:0];
    // Write takes effect at the edge where waitrequest is seen low
    assign wr_take = AVS_WRITE && !wait_reg && AVS_BYTEENABLE[0] && wr_dec[6];
    assign start_req = force_parity_error_go_reg || entry_req_reg;
    assign sense_pin0 = sensor_control_zero_reg[0];

    // Pin inputs pass two flip-flops
    assign sync_in = {VOLTAGE0_LEVEL, FRAME_VALID_PIN, LINE_VALID_PIN};

    vfbsr_sync #(
        .WIDTH(5)
    ) u_sync (
        .CLOCK(CLOCK),
        .SYS_RST(SYS_RST),
        .CLK_EN(CLK_EN),
        .ASYNC_IN(sync_in),
        .SYNC_OUT(sync_out)
    );

    // Read value mux
    always_comb begin
        case (rd_dec[5:0])
            IDX_PIN_INPUT_CONTROL: read_value = pin_input_control_reg;
            IDX_RESERVED_0F: read_value = reserved_0f_reg & MASK_RESERVED_0F;
            IDX_VIDEO_PORT_CONFIG: read_value = video_port_config_reg;
            IDX_VIDEO_TYPE_MATCH_VALUE: read_value = video_type_match_value_reg;
            IDX_RESERVED_12: read_value = reserved_12_reg;
            IDX_FORCED_TEST_ERROR: read_value = {force_parity_error_go_reg,
                                                 forced_parity_error_count_reg};
            IDX_TEST_MODE_CONTROL: read_value = test_mode_control_reg;
            IDX_SENSOR_VOLTAGE_GAIN: read_value = sensor_voltage_gain_reg;
            IDX_RESERVED_16: read_value = reserved_16_reg;
            IDX_SENSOR_CONTROL_ZERO: read_value = sensor_control_zero_reg;
            IDX_SENSOR_CONTROL_ONE: read_value = sensor_control_one_reg;
            IDX_VOLTAGE0_THRESHOLDS: read_value = voltage0_thresholds_reg;
            default: read_value = 8'h00;
        endcase
    end

    // Bus handshake: one wait cycle, then a one-cycle answer
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wait_reg <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else if (CLK_EN) begin
            wait_reg <= !((AVS_READ || AVS_WRITE) && wait_reg);
            if (AVS_READ && wait_reg) begin
                AVS_READDATA <= rd_dec[6] ? {24'h000000, read_value} : 32'h00000000;
            end
        end
    end

    assign AVS_WAITREQUEST = wait_reg;

    // Plain read/write registers
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pin_input_control_reg <= RST_PIN_INPUT_CONTROL;
            reserved_0f_reg <= RST_RESERVED_0F;
            video_port_config_reg <= RST_VIDEO_PORT_CONFIG;
            reserved_12_reg <= RST_RESERVED_12;
            test_mode_control_reg <= RST_TEST_MODE_CONTROL;
            sensor_voltage_gain_reg <= RST_SENSOR_VOLTAGE_GAIN;
            reserved_16_reg <= RST_RESERVED_16;
            sensor_control_zero_reg <= RST_SENSOR_CONTROL_ZERO;
            sensor_control_one_reg <= RST_SENSOR_CONTROL_ONE;
            voltage0_thresholds_reg <= RST_VOLTAGE0_THRESHOLDS;
        end else if (CLK_EN && wr_take) begin
            case (wr_dec[5:0])
                IDX_PIN_INPUT_CONTROL: pin_input_control_reg <= wdata;
                IDX_RESERVED_0F: reserved_0f_reg <= wdata & MASK_RESERVED_0F;
                IDX_VIDEO_PORT_CONFIG: video_port_config_reg <= wdata;
                IDX_RESERVED_12: reserved_12_reg <= wdata;
                IDX_TEST_MODE_CONTROL: test_mode_control_reg <= wdata;
                IDX_SENSOR_VOLTAGE_GAIN: sensor_voltage_gain_reg <= wdata;
                IDX_RESERVED_16: reserved_16_reg <= wdata;
                IDX_SENSOR_CONTROL_ZERO: sensor_control_zero_reg <= wdata;
                IDX_SENSOR_CONTROL_ONE: sensor_control_one_reg <= wdata;
                IDX_VOLTAGE0_THRESHOLDS: voltage0_thresholds_reg <= wdata;
                default: ;
            endcase
        end
    end

    // Match value, locked while matching is on
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            video_type_match_value_reg <= RST_VIDEO_TYPE_MATCH_VALUE;
        end else if (CLK_EN && wr_take && wr_dec[5:0] == IDX_VIDEO_TYPE_MATCH_VALUE
                     && !video_port_config_reg[BIT_TYPE_MATCH_ENABLE]) begin
            video_type_match_value_reg <= wdata;
        end
    end

    // Error count and self-clearing go bit; a new set beats the clear
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            forced_parity_error_count_reg <= RST_FORCED_TEST_ERROR[6:0];
            force_parity_error_go_reg <= RST_FORCED_TEST_ERROR[BIT_FORCE_GO];
        end else if (CLK_EN) begin
            if (wr_take && wr_dec[5:0] == IDX_FORCED_TEST_ERROR) begin
                forced_parity_error_count_reg <= wdata[6:0];
            end
            if (wr_take && wr_dec[5:0] == IDX_FORCED_TEST_ERROR && wdata[BIT_FORCE_GO]) begin
                force_parity_error_go_reg <= 1'b1;
            end else if (start_req) begin
                force_parity_error_go_reg <= 1'b0;
            end
        end
    end

    // Test mode entry and nonzero force field raise an internal request
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            local_prev_reg <= 1'b0;
            entry_req_reg <= 1'b0;
        end else if (CLK_EN) begin
            local_prev_reg <= test_mode_control_reg[BIT_LOCAL_TEST_MODE];
            if (test_mode_control_reg[BIT_LOCAL_TEST_MODE] && !local_prev_reg) begin
                entry_req_reg <= 1'b1;
            end else if (wr_take && wr_dec[5:0] == IDX_TEST_MODE_CONTROL
                         && wdata[7:4] != 4'h0) begin
                entry_req_reg <= 1'b1;
            end else if (start_req) begin
                entry_req_reg <= 1'b0;
            end
        end
    end

    // Injector: one parity error pulse per cycle, count as programmed
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            inj_state_reg <= INJ_IDLE;
            inj_cnt_reg <= 7'h00;
            PARITY_ERROR_INJECT <= 1'b0;
        end else if (CLK_EN) begin
            PARITY_ERROR_INJECT <= 1'b0;
            if (start_req) begin
                inj_cnt_reg <= forced_parity_error_count_reg;
                inj_state_reg <= (forced_parity_error_count_reg != 7'h00) ? INJ_RUN : INJ_IDLE;
            end else begin
                case (inj_state_reg)
                    INJ_IDLE: inj_state_reg <= INJ_IDLE;
                    INJ_RUN: begin
                        PARITY_ERROR_INJECT <= 1'b1;
                        inj_cnt_reg <= inj_cnt_reg - 7'h01;
                        if (inj_cnt_reg == 7'h01) begin
                            inj_state_reg <= INJ_IDLE;
                        end
                    end
                    default: inj_state_reg <= INJ_IDLE;
                endcase
            end
        end
    end

    // Packet filter result, one cycle after the strobe
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            PKT_PASS_STROBE <= 1'b0;
            PKT_PASS <= 1'b0;
        end else if (CLK_EN) begin
            PKT_PASS_STROBE <= PKT_TYPE_STROBE;
            PKT_PASS <= PKT_TYPE_STROBE && pass_decide(PKT_TYPE_CODE, video_port_config_reg,
                video_type_match_value_reg[5:0], VIDEO_100MHZ_MODE);
        end
    end

    // Sync polarity, test, sensor and alarm outputs
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            FRAME_VALID_OUT <= 1'b0;
            LINE_VALID_OUT <= 1'b0;
            TEST_CLOCK_SOURCE <= CLK_SRC_EXTERNAL;
            FORWARD_ERROR_FORCE <= 1'b0;
            SENSORS_ENABLE <= 1'b0;
            VOLTAGE_SENSE_PIN0 <= 1'b0;
            VOLTAGE_SENSE_PIN1 <= 1'b0;
            GAIN_APPLY <= 1'b0;
            VOLTAGE0_HIGH_ALARM <= 1'b0;
            VOLTAGE0_LOW_ALARM <= 1'b0;
        end else if (CLK_EN) begin
            FRAME_VALID_OUT <= sync_out[1] ^ video_port_config_reg[BIT_FRAME_VALID_INVERT];
            LINE_VALID_OUT <= sync_out[0] ^ video_port_config_reg[BIT_LINE_VALID_INVERT];
            if (test_mode_control_reg[2]) begin
                TEST_CLOCK_SOURCE <= CLK_SRC_INT_25;
            end else if (test_mode_control_reg[1]) begin
                TEST_CLOCK_SOURCE <= CLK_SRC_INT_50;
            end else begin
                TEST_CLOCK_SOURCE <= CLK_SRC_EXTERNAL;
            end
            FORWARD_ERROR_FORCE <= test_mode_control_reg[7:4] != 4'h0;
            SENSORS_ENABLE <= sensor_control_zero_reg[3:2] == SENSORS_ON;
            VOLTAGE_SENSE_PIN0 <= sense_pin0;
            VOLTAGE_SENSE_PIN1 <= sensor_control_zero_reg[1];
            GAIN_APPLY <= sensor_control_one_reg[BIT_GAIN_ENABLE];
            VOLTAGE0_HIGH_ALARM <= sense_pin0
                && sync_out[4:2] > voltage0_thresholds_reg[6:4];
            VOLTAGE0_LOW_ALARM <= sense_pin0
                && sync_out[4:2] < voltage0_thresholds_reg[2:0];
        end
    end

    // Direct register fields
    assign PIN_INPUT_ENABLE = pin_input_control_reg[3:0];
    assign PIN0_OUTPUT_ENABLE = pin_input_control_reg[BIT_PIN0_OUTPUT_ENABLE];
    assign LOCAL_TEST_MODE = test_mode_control_reg[BIT_LOCAL_TEST_MODE];
    assign REMOTE_TEST_ENABLE = test_mode_control_reg[BIT_REMOTE_TEST_ENABLE];
    assign GAIN_DIVISOR = sensor_voltage_gain_reg[6:0];

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST || !CLK_EN);

    logic [7:0] pulse_seen_reg;
    logic [7:0] pulse_load_reg;

    // Pulse counter for the injector check
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pulse_seen_reg <= 8'h00;
            pulse_load_reg <= 8'h00;
        end else if (CLK_EN) begin
            if (start_req) begin
                pulse_seen_reg <= 8'h00;
                pulse_load_reg <= {1'b0, forced_parity_error_count_reg};
            end else if (PARITY_ERROR_INJECT) begin
                pulse_seen_reg <= pulse_seen_reg + 8'h01;
            end
        end
    end

    sequence go_written_s;
        wr_take && wr_dec[5:0] == IDX_FORCED_TEST_ERROR && wdata[BIT_FORCE_GO];
    endsequence

    sequence go_cleared_s;
        force_parity_error_go_reg ##1 !force_parity_error_go_reg;
    endsequence

    sequence fv_steady_s;
        ($stable(FRAME_VALID_PIN) && $stable(video_port_config_reg))[*4];
    endsequence

    bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer not after one wait cycle");
    pin_input_a: assert property (wr_take && wr_dec[5:0] == IDX_PIN_INPUT_CONTROL
        |=> PIN_INPUT_ENABLE == $past(AVS_WRITEDATA[3:0]))
        else $error("pin input enables not written");
    pin_output_a: assert property (wr_take && wr_dec[5:0] == IDX_PIN_INPUT_CONTROL
        |=> PIN0_OUTPUT_ENABLE == $past(AVS_WRITEDATA[4]))
        else $error("pin 0 output enable not written");
    any_long_a: assert property (PKT_TYPE_STROBE && PKT_TYPE_CODE[5:4] != 2'h0
        && video_port_config_reg[BIT_ANY_LONG_TYPE_PASS] |=> PKT_PASS && PKT_PASS_STROBE)
        else $error("long type not passed");
    type_match_a: assert property (PKT_TYPE_STROBE
        && video_port_config_reg[BIT_TYPE_MATCH_ENABLE]
        && video_type_match_value_reg[5:4] != 2'h0
        && PKT_TYPE_CODE == video_type_match_value_reg[5:0] |=> PKT_PASS)
        else $error("matching type not passed");
    match_lock_a: assert property (wr_take
        && wr_dec[5:0] == IDX_VIDEO_TYPE_MATCH_VALUE
        && video_port_config_reg[BIT_TYPE_MATCH_ENABLE] |=> $stable(video_type_match_value_reg))
        else $error("match value changed while locked");
    yuv_pass_a: assert property (PKT_TYPE_STROBE && VIDEO_100MHZ_MODE
        && video_port_config_reg[BIT_YUV10_TYPE_PASS] && PKT_TYPE_CODE == YUV10_CODE_B
        |=> PKT_PASS)
        else $error("yuv type not passed");
    fv_invert_a: assert property (fv_steady_s |-> FRAME_VALID_OUT
        == (FRAME_VALID_PIN ^ video_port_config_reg[BIT_FRAME_VALID_INVERT]))
        else $error("frame valid polarity wrong");
    short_match_a: assert property (PKT_TYPE_STROBE && video_port_config_reg[4:2] == 3'h2
        && video_type_match_value_reg[5:4] == 2'h0 |=> !PKT_PASS)
        else $error("short stored type matched");
    inject_count_a: assert property (inj_state_reg == INJ_RUN && inj_cnt_reg == 7'h01
        && !start_req ##1 !start_req |=> pulse_seen_reg == pulse_load_reg)
        else $error("wrong number of injected errors");
    test_entry_a: assert property ($rose(test_mode_control_reg[BIT_LOCAL_TEST_MODE])
        && forced_parity_error_count_reg != 7'h00 |-> ##[1:4] PARITY_ERROR_INJECT)
        else $error("no injection on test mode entry");
    go_clear_a: assert property (go_written_s |=> go_cleared_s)
        else $error("go bit not self-cleared");
    clock_select_a: assert property (test_mode_control_reg[2:1] == 2'h1
        |=> TEST_CLOCK_SOURCE == CLK_SRC_INT_50)
        else $error("test clock source wrong");
    high_alarm_a: assert property (sense_pin0
        && sync_out[4:2] > voltage0_thresholds_reg[6:4] |=> VOLTAGE0_HIGH_ALARM)
        else $error("high alarm missing");
    low_alarm_a: assert property (!sense_pin0 |=> !VOLTAGE0_LOW_ALARM)
        else $error("low alarm without pin 0 sensing");
    reserved_read_a: assert property (AVS_READ && !AVS_WAITREQUEST
        && rd_dec[6] && rd_dec[5:0] == IDX_RESERVED_0F |-> AVS_READDATA[31:4] == 28'h0)
        else $error("read-only reserved bits not zero");

endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
    import vfbsr_pkg::*;
    logic clk = 0, rst = 1, rd = 0, wr = 0, fv = 0, m100 = 0, ps = 0, wq, pst, pass, inj, hi, lo, fvo;
    logic [7:0] adr = 0;
    logic [31:0] wd = 0, rdv, rq;
    logic [5:0] pc = 0;
    logic [2:0] vl = 3'h7;
    logic [1:0] tcs;
    logic lvo;
    logic [3:0] pie;
    logic [6:0] gd;
    wire [7:0] ctl;
    int fails = 0, num_checks = 0, pulses = 0;
    logic [7:0] rv [12] = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h18,
        8'h0C, 8'h80, 8'h62};
    // Clock and pulse counter
    always #5 clk = ~clk;
    always @(posedge clk) if (inj === 1'b1) pulses++;
    vfbsr_top dut (.CLOCK(clk), .SYS_RST(rst), .CLK_EN(1'b1), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rq),
        .AVS_WAITREQUEST(wq), .PIN_INPUT_ENABLE(pie), .PIN0_OUTPUT_ENABLE(ctl[7]),
        .FRAME_VALID_PIN(fv), .LINE_VALID_PIN(1'b0), .FRAME_VALID_OUT(fvo), .LINE_VALID_OUT(lvo),
        .VIDEO_100MHZ_MODE(m100), .PKT_TYPE_STROBE(ps), .PKT_TYPE_CODE(pc),
        .PKT_PASS_STROBE(pst), .PKT_PASS(pass), .LOCAL_TEST_MODE(ctl[6]),
        .REMOTE_TEST_ENABLE(ctl[5]), .TEST_CLOCK_SOURCE(tcs), .FORWARD_ERROR_FORCE(ctl[4]),
        .PARITY_ERROR_INJECT(inj), .SENSORS_ENABLE(ctl[3]), .VOLTAGE_SENSE_PIN0(ctl[2]),
        .VOLTAGE_SENSE_PIN1(ctl[1]), .GAIN_DIVISOR(gd), .GAIN_APPLY(ctl[0]), .VOLTAGE0_LEVEL(vl),
        .VOLTAGE0_HIGH_ALARM(hi), .VOLTAGE0_LOW_ALARM(lo));
    task end_sim();
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(logic [31:0] a, logic [31:0] e);
        num_checks++;
        if (a !== e) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low
    task bus(logic w, logic [5:0] idx, logic [7:0] d);
        int n;
        rd <= ~w;
        wr <= w;
        adr <= {idx, 2'h0};
        wd <= {24'h0, d};
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wq === 1'b0) break;
        end
        rdv = rq;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (n == 50) begin
            fails++;
            end_sim();
        end
    endtask
    task rchk(logic [5:0] idx, logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(rdv, {24'h0, e});
    endtask
    task pkt(logic [5:0] c, logic e);
        ps <= 1'b1;
        pc <= c;
        @(posedge clk);
        ps <= 1'b0;
        #1 chk({pst, pass}, {1'b1, e});
        @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values of every register
        for (int i = 0; i < 12; i++) rchk(6'h0E + i[5:0], rv[i]);
        chk({pie, gd, ctl}, {4'hF, 7'h20, 8'h09});
        bus(1'b1, 6'h0E, 8'h15);
        chk({pie, ctl[7]}, 5'h0B);
        bus(1'b1, 6'h0F, 8'hFF);
        rchk(6'h0F, 8'h0F);
        chk({hi, lo}, 2'h0);
        // Packet filter modes
        bus(1'b1, 6'h10, 8'h10);
        pkt(6'h2A, 1'b1);
        pkt(6'h05, 1'b0);
        bus(1'b1, 6'h10, 8'h04);
        m100 <= 1'b1;
        pkt(6'h1D, 1'b1);
        pkt(6'h19, 1'b1);
        pkt(6'h1F, 1'b1);
        m100 <= 1'b0;
        pkt(6'h1F, 1'b0);
        bus(1'b1, 6'h11, 8'h05);
        bus(1'b1, 6'h10, 8'h0B);
        pkt(6'h05, 1'b0);
        bus(1'b1, 6'h10, 8'h03);
        bus(1'b1, 6'h11, 8'h25);
        bus(1'b1, 6'h10, 8'h0B);
        bus(1'b1, 6'h11, 8'h3F);
        rchk(6'h11, 8'h25);
        pkt(6'h25, 1'b1);
        pkt(6'h26, 1'b0);
        repeat (4) @(posedge clk);
        chk({fvo, lvo}, 2'h3);
        fv <= 1'b1;
        repeat (4) @(posedge clk);
        chk({fvo, lvo}, 2'h1);
        // Forced parity errors
        pulses = 0;
        bus(1'b1, 6'h13, 8'h83);
        repeat (10) @(posedge clk);
        chk(pulses, 3);
        rchk(6'h13, 8'h03);
        bus(1'b1, 6'h14, 8'h06);
        @(posedge clk);
        chk(tcs, CLK_SRC_INT_25);
        // Test mode entry and force field both start injection
        pulses = 0;
        bus(1'b1, 6'h14, 8'h0A);
        repeat (10) @(posedge clk);
        chk({tcs, pulses[3:0]}, {CLK_SRC_INT_50, 4'h3});
        bus(1'b1, 6'h14, 8'h31);
        repeat (10) @(posedge clk);
        chk({ctl, pulses[3:0]}, {8'hB9, 4'h6});
        // Voltage 0 alarms
        bus(1'b1, 6'h17, 8'h0D);
        repeat (5) @(posedge clk);
        chk({ctl[3:1], hi, lo}, 5'h1A);
        vl <= 3'h0;
        repeat (5) @(posedge clk);
        chk({hi, lo}, 2'h1);
        end_sim();
    end
endmodule
